// file: logic/pointer_arith_call_ops.sv
// Module: execution of pointer add, add-and-return and computed call
`timescale 1ns/1ps
module pointer_arith_call_ops (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Instruction issue
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic extended_set_enable_in,
  // Core state sources
  input wire logic [7:0] working_register_file_in,
  input wire logic [7:0] pc_high_latch_in,
  input wire logic [7:0] pc_upper_latch_in,
  input wire logic [20:0] return_stack_top_in,
  // Program counter
  output logic [20:0] pc_out,
  // Return stack control
  output logic push_out,
  output logic [20:0] push_data_out,
  output logic pop_out,
  // Pointer registers
  output logic [11:0] ptr0_out,
  output logic [11:0] ptr1_out,
  output logic [11:0] stack_pointer_register_out,
  // Status
  output logic busy_out,
  output logic status_write_out,
  output logic [1:0] phase_out
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [1:0] phase_reg;
  ptr_ops_pkg::exec_state_t state_reg;
  logic [1:0] sel;
  logic [5:0] lit;
  logic is_add;
  logic is_ret;
  logic is_call;
  logic issue;
  logic [11:0] ptr_val [3];
  logic [2:0] ptr_wr;
  logic [11:0] sum;
  logic [20:0] pc_reg;

  assign sel = instr_in[ptr_ops_pkg::SEL_HI_POS:ptr_ops_pkg::SEL_LO_POS];
  assign lit = instr_in[ptr_ops_pkg::LIT_HI_POS:0];
  // Issue only at the last phase while not busy, so at most one instruction is taken per cycle
  assign issue = instr_valid_in && (state_reg == ptr_ops_pkg::EXEC_ST) && (phase_reg == ptr_ops_pkg::LAST_PHASE);
  // Extended opcodes are ignored unless the enable strap is set
  assign is_add = issue && extended_set_enable_in && (instr_in[15:8] == ptr_ops_pkg::ADD_PTR_HI);
  assign is_ret = is_add && (sel == ptr_ops_pkg::SEL_STACK_RET);
  assign is_call = issue && extended_set_enable_in && (instr_in == ptr_ops_pkg::COMPUTED_CALL_OP);
  // Selected pointer; select three maps to the stack pointer
  always_comb begin
    sel_ptr_sum : begin
      if (sel == ptr_ops_pkg::SEL_STACK_RET) begin
        sum = ptr_val[ptr_ops_pkg::SEL_STACK_PTR] + {6'h00, lit};
      end else begin
        sum = ptr_val[sel] + {6'h00, lit};
      end
    end
  end
  // Write strobes; add-and-return only touches the stack pointer
  always_comb begin
    ptr_wr = 3'h0;
    if (is_add) begin
      if (is_ret) begin
        ptr_wr[ptr_ops_pkg::SEL_STACK_PTR] = 1'b1;
      end else begin
        ptr_wr[sel] = 1'b1;
      end
    end
  end
  // ----------------------------------------
  // Pointer storage
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < ptr_ops_pkg::NUM_PTRS; gi++) begin : g_ptr
      ptr_slot u_slot (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .wr_en_in(ptr_wr[gi]),
        .wr_data_in(sum),
        .value_out(ptr_val[gi])
      );
    end
  endgenerate
  assign ptr0_out = ptr_val[0];
  assign ptr1_out = ptr_val[1];
  assign stack_pointer_register_out = ptr_val[2];
  // ----------------------------------------
  // Phase counter
  // ----------------------------------------
  // Four phases per instruction cycle, free running
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      phase_reg <= ptr_ops_pkg::FIRST_PHASE;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  assign phase_out = phase_reg;
  // ----------------------------------------
  // Two-cycle sequencing
  // ----------------------------------------
  // Return and call insert one idle cycle while the target is fetched
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_reg <= ptr_ops_pkg::EXEC_ST;
    end else begin
      case (state_reg)
        ptr_ops_pkg::EXEC_ST: begin
          if (is_ret || is_call) begin
            state_reg <= ptr_ops_pkg::BUBBLE_ST;
          end
        end
        ptr_ops_pkg::BUBBLE_ST: begin
          if (phase_reg == ptr_ops_pkg::LAST_PHASE) begin
            state_reg <= ptr_ops_pkg::EXEC_ST;
          end
        end
        default: state_reg <= ptr_ops_pkg::EXEC_ST;
      endcase
    end
  end
  assign busy_out = (state_reg == ptr_ops_pkg::BUBBLE_ST);
  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  // Call: low byte from working register, upper bytes from latches
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pc_reg <= ptr_ops_pkg::PC_RESET;
    end else if (is_call) begin
      pc_reg <= {pc_upper_latch_in[4:0], pc_high_latch_in, working_register_file_in};
    end else if (is_ret) begin
      pc_reg <= return_stack_top_in;
    end else if (issue) begin
      pc_reg <= pc_reg + ptr_ops_pkg::PC_STEP;
    end
  end
  assign pc_out = pc_reg;
  // Return stack push comes on the same clock edge as the jump, carrying the pre-jump address plus two
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      push_out <= 1'b0;
      push_data_out <= ptr_ops_pkg::PC_RESET;
      pop_out <= 1'b0;
    end else begin
      push_out <= is_call;
      push_data_out <= pc_reg + ptr_ops_pkg::PC_STEP;
      pop_out <= is_ret;
    end
  end
  // No flag, working, status or bank writes from this block
  assign status_write_out = 1'b0;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Every check runs on the core clock and sleeps while reset is held
  default clocking assert_cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  // Call taken, then its push pulse on the next clock
  sequence s_call_issue;
    is_call ##1 push_out;
  endsequence
  // Return taken, then its pop pulse on the next clock
  sequence s_ret_issue;
    is_ret ##1 pop_out;
  endsequence
  // Idle second cycle: four busy clocks, then free again
  sequence s_bubble;
    busy_out [*4] ##1 !busy_out;
  endsequence
  // Pushed address is the call's own address plus two
  a_call_push_addr: assert property (
    is_call |=> push_data_out == $past(pc_reg) + ptr_ops_pkg::PC_STEP)
    else $error("call push address wrong");
  // Push lasts one clock, so the return stack takes one entry per call
  a_push_single: assert property (
    push_out |=> !push_out)
    else $error("push longer than one clock");
  // New target: low byte from working register, upper bytes from latches
  a_call_pc_load: assert property (
    is_call |=> pc_reg[7:0] == $past(working_register_file_in) && pc_reg[15:8] == $past(pc_high_latch_in)
      && pc_reg[20:16] == $past(pc_upper_latch_in[4:0]))
    else $error("call target wrong");
  // Call occupies a second, idle cycle
  a_call_two_cyc: assert property (
    s_call_issue |-> s_bubble)
    else $error("call not two cycles");
  // Return occupies a second, idle cycle
  a_ret_two_cyc: assert property (
    s_ret_issue |-> s_bubble)
    else $error("return not two cycles");
  // Nothing is taken during the idle cycle, so the pointers hold
  a_busy_hold: assert property (
    busy_out |=> $stable(ptr0_out) && $stable(ptr1_out) && $stable(stack_pointer_register_out))
    else $error("pointer changed while busy");
  // Return loads the top of the return stack and pops it
  a_ret_pc_tos: assert property (
    is_ret |=> pc_reg == $past(return_stack_top_in) && pop_out)
    else $error("return pc wrong");
  // Plain add with select zero writes the sum back to pointer 0
  a_add_sum: assert property (
    is_add && !is_ret && sel == 2'h0 |=> ptr0_out == $past(ptr_val[0]) + {6'h00, $past(lit)})
    else $error("pointer add wrong");
  // Add-and-return leaves the other two pointers alone
  a_ret_only_sp: assert property (
    is_ret |=> $stable(ptr0_out) && $stable(ptr1_out))
    else $error("return touched pointer");
  // Add-and-return adds its literal to the stack pointer
  a_ret_sp_sum: assert property (
    is_ret |=> stack_pointer_register_out == $past(ptr_val[2]) + {6'h00, $past(lit)})
    else $error("return stack pointer sum wrong");
  // With the extended set off, an issued word changes no pointer and starts no jump
  a_disabled_ignore: assert property (
    issue && !extended_set_enable_in |=> $stable(ptr0_out) && $stable(ptr1_out)
      && $stable(stack_pointer_register_out) && !push_out && !pop_out && !busy_out)
    else $error("decode while disabled");
  // Status is never written by any of these instructions
  a_no_flags: assert property (
    (is_add || is_call) |=> !status_write_out)
    else $error("flags written");
  // The exact call word starts a call when the extended set is on
  a_call_opcode: assert property (
    issue && extended_set_enable_in && instr_in == 16'h0014 |=> push_out && busy_out)
    else $error("call decode wrong");
  // Any other word never starts a call
  a_call_exact: assert property (
    issue && instr_in != 16'h0014 |=> !push_out)
    else $error("call decoded from wrong word");
endmodule : pointer_arith_call_ops

// file: logic/ptr_ops_pkg.sv
// Package: constants for the pointer arithmetic and computed call execution block
package ptr_ops_pkg;
  // ----------------------------------------
  // Opcode patterns
  // ----------------------------------------
  localparam logic [7:0] ADD_PTR_HI = 8'hE8;
  localparam logic [15:0] COMPUTED_CALL_OP = 16'h0014;
  localparam logic [1:0] SEL_STACK_RET = 2'h3;
  localparam logic [1:0] SEL_STACK_PTR = 2'h2;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SEL_HI_POS = 7;
  localparam int SEL_LO_POS = 6;
  localparam int LIT_HI_POS = 5;
  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int PTR_W = 12;
  localparam int PC_W = 21;
  localparam int NUM_PTRS = 3;
  localparam logic [11:0] PTR_RESET = 12'h000;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  // Phase count per instruction cycle
  localparam logic [1:0] LAST_PHASE = 2'h3;
  localparam logic [1:0] FIRST_PHASE = 2'h0;
  // Execution states
  typedef enum logic [1:0] {EXEC_ST, BUBBLE_ST} exec_state_t;
endpackage : ptr_ops_pkg

// file: logic/ptr_slot.sv
// Module: one indirect pointer register with a write port
`timescale 1ns/1ps
module ptr_slot (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [11:0] wr_data_in,
  // Stored value
  output logic [11:0] value_out
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Holds pointer; loads only on write strobe
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      value_out <= ptr_ops_pkg::PTR_RESET;
    end else if (wr_en_in) begin
      value_out <= wr_data_in;
    end
  end
endmodule : ptr_slot

// file: verification/pointer_arith_call_ops_test.sv
// Testbench for the pointer add, add-and-return and computed call block
`timescale 1ns/1ps
module pointer_arith_call_ops_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk_in, rst_in, instr_valid_in, extended_set_enable_in;
  logic [15:0] instr_in;
  logic [7:0] working_register_file_in, pc_high_latch_in, pc_upper_latch_in;
  logic [20:0] return_stack_top_in, pc_out, push_data_out, exp_pc;
  logic push_out, pop_out, busy_out, status_write_out;
  logic [11:0] ptr0_out, ptr1_out, stack_pointer_register_out;
  logic [11:0] exp_ptr [3]; // Expected pointer values
  logic [1:0] phase_out;
  int fail_count, total_checks;
  pointer_arith_call_ops dut (.core_clk_in, .rst_in, .instr_valid_in, .instr_in, .extended_set_enable_in,
    .working_register_file_in, .pc_high_latch_in, .pc_upper_latch_in, .return_stack_top_in, .pc_out,
    .push_out, .push_data_out, .pop_out, .ptr0_out, .ptr1_out, .stack_pointer_register_out, .busy_out,
    .status_write_out, .phase_out);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string what, input logic [20:0] seen, input logic [20:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Waits for a free phase 2, so the word is present at the phase 3 take edge
  task issue(input logic [15:0] word);
    int n;
    n = 0;
    @(negedge core_clk_in);
    while (!(phase_out === 2'h2 && busy_out === 1'b0) && n < 40) begin
      n++;
      @(negedge core_clk_in);
    end
    @(posedge core_clk_in);
    instr_valid_in <= 1'b1;
    instr_in <= word;
    @(posedge core_clk_in);
    instr_valid_in <= 1'b0;
    @(negedge core_clk_in);
  endtask : issue
  task chk_state;
    chk("ptr0", {9'h000, ptr0_out}, {9'h000, exp_ptr[0]});
    chk("ptr1", {9'h000, ptr1_out}, {9'h000, exp_ptr[1]});
    chk("sp", {9'h000, stack_pointer_register_out}, {9'h000, exp_ptr[2]});
    chk("pc", pc_out, exp_pc);
    chk("status", {20'h00000, status_write_out}, 21'h000000);
    chk("phase", {19'h00000, phase_out}, 21'h000000);
  endtask : chk_state
  // Second cycle of a jump is idle: busy stays up, pc holds, pulses last one clock
  task bubble_chk;
    @(negedge core_clk_in);
    chk("pulses", {19'h00000, push_out, pop_out}, 21'h000000);
    repeat (2) @(negedge core_clk_in);
    chk("busy4", {20'h00000, busy_out}, 21'h000001);
    @(negedge core_clk_in);
    chk("busy5", {20'h00000, busy_out}, 21'h000000);
    chk_state();
  endtask : bubble_chk
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task test_add;
    for (int k = 0; k < 2; k++) begin
      for (int s = 0; s < 3; s++) begin
        issue({ptr_ops_pkg::ADD_PTR_HI, s[1:0], (k == 0) ? 6'h3F : 6'h01});
        exp_ptr[s] = exp_ptr[s] + ((k == 0) ? 12'h03F : 12'h001);
        exp_pc = exp_pc + ptr_ops_pkg::PC_STEP;
        chk_state();
      end
    end
  endtask : test_add
  task test_return;
    issue({ptr_ops_pkg::ADD_PTR_HI, 2'h3, 6'h05});
    exp_ptr[2] = exp_ptr[2] + 12'h005;
    exp_pc = return_stack_top_in;
    chk_state();
    chk("pop", {19'h00000, push_out, pop_out}, 21'h000001);
    chk("busy1", {20'h00000, busy_out}, 21'h000001);
    bubble_chk();
  endtask : test_return
  task test_call;
    issue(16'h0014);
    chk("push_data", push_data_out, exp_pc + 21'h000002);
    exp_pc = {5'h05, 8'h10, 8'h06};
    chk_state();
    chk("push", {19'h00000, push_out, pop_out}, 21'h000002);
    chk("busy1", {20'h00000, busy_out}, 21'h000001);
    bubble_chk();
  endtask : test_call
  task test_ignored;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk_in);
      extended_set_enable_in <= (i == 2);
      issue((i == 0) ? 16'hE807 : (i == 1) ? 16'h0014 : 16'h0015);
      exp_pc = exp_pc + ptr_ops_pkg::PC_STEP;
      chk_state();
      chk("no_push", {20'h00000, push_out}, 21'h000000);
    end
    @(posedge core_clk_in);
    extended_set_enable_in <= 1'b1;
  endtask : test_ignored
  // Reset pulse in mid-run: every output returns to zero and the next add works
  task test_reset;
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(negedge core_clk_in);
    exp_pc = 21'h000000;
    for (int i = 0; i < 3; i++) exp_ptr[i] = 12'h000;
    chk_state();
    chk("idle", {18'h00000, push_out, pop_out, busy_out}, 21'h000000);
    issue({ptr_ops_pkg::ADD_PTR_HI, 2'h1, 6'h22});
    exp_ptr[1] = 12'h022;
    exp_pc = ptr_ops_pkg::PC_STEP;
    chk_state();
  endtask : test_reset
  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // Clock at 20 MHz
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  // Watchdog well beyond the roughly 80 clocks the tests need
  initial begin
    repeat (5000) @(posedge core_clk_in);
    fail_count++;
    test_done();
  end
  // Main sequence
  initial begin
    rst_in = 1'b1;
    instr_valid_in = 1'b0;
    instr_in = 16'hFFFF;
    extended_set_enable_in = 1'b1;
    working_register_file_in = 8'h06;
    pc_high_latch_in = 8'h10;
    pc_upper_latch_in = 8'hE5; // Only the low five bits reach the PC
    return_stack_top_in = 21'h012344;
    exp_pc = 21'h000000;
    for (int i = 0; i < 3; i++) exp_ptr[i] = 12'h000;
    fail_count = 0;
    total_checks = 0;
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(negedge core_clk_in);
    chk_state();
    test_add();
    test_return();
    test_call();
    test_ignored();
    test_reset();
    test_done();
  end
endmodule : pointer_arith_call_ops_test
